// [sipo_pkg.sv]
package sipo_pkg;
  localparam int SIPO_WIDTH = 16;
  localparam int SIPO_IDX_W = 4;
  localparam logic [15:0] SIPO_SHIFT_RST = 16'h0000;
  localparam logic [15:0] SIPO_LATCH_RST = 16'h0000;
  localparam logic [15:0] SIPO_CLEARED = 16'h0000;
  // Host link ceiling, checked against clk rate of 100 MHz
  localparam int SIPO_LINK_MHZ = 5;
  localparam int SIPO_CLK_MHZ = 100;
  localparam int SIPO_MIN_SCK_CYC = SIPO_CLK_MHZ / SIPO_LINK_MHZ;
endpackage

// [sipo_stage.sv]
`timescale 1ns/1ps
// One bit of shift chain plus its output latch
module sipo_stage (
  input wire logic clk,
  input wire logic reset,
  input wire logic shift_en,
  input wire logic shift_in,
  input wire logic latch_load,
  input wire logic latch_clear,
  output logic shift_q,
  output logic latch_q
);
  import sipo_pkg::*;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= 1'b0;
    end else if (shift_en) begin
      shift_q <= shift_in;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_q <= 1'b0;
    end else if (latch_clear) begin
      latch_q <= 1'b0;
    end else if (latch_load) begin
      // Take the post-shift value so the output has no extra lag
      latch_q <= shift_en ? shift_in : shift_q;
    end
  end
endmodule

// [sipo_expander.sv]
`timescale 1ns/1ps
module sipo_expander (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_data,
  input wire logic shift_clock,
  input wire logic latch_strobe_n,
  input wire logic output_clear_n,
  output logic [sipo_pkg::SIPO_WIDTH-1:0] parallel_outputs,
  output logic serial_out
);
  import sipo_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Shift clock edge detect; pins are already synchronous to clk
  logic sck_prev_r;
  logic [SIPO_WIDTH-1:0] shift_q;
  logic [SIPO_WIDTH-1:0] latch_q;
  logic [SIPO_WIDTH-1:0] stage_in;
  logic [SIPO_WIDTH-1:0] shift_nxt;
  logic [SIPO_WIDTH-1:0] chain_in;
  logic [SIPO_WIDTH-1:0] chain_q;
  wire sck_rise = shift_clock & ~sck_prev_r;
  wire clear_act = ~output_clear_n;
  // Transparent latch: with strobe low, copy the value the stage is taking
  wire latch_open = ~latch_strobe_n;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sck_prev_r <= 1'b0;
    end else begin
      sck_prev_r <= shift_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next shift contents seen by the latches, so the output tracks
  // the shift without an extra cycle of lag
  assign shift_nxt = sck_rise ? {shift_q[SIPO_WIDTH-2:0], serial_data}
                              : shift_q;
  assign stage_in = shift_nxt;
  assign chain_in = {shift_r[SIPO_WIDTH-2:0], serial_data};

  // Clear not wired to the shift chain: it only blanks the latches
  genvar gi;
  generate
    for (gi = 0; gi < SIPO_WIDTH; gi++) begin : g_stage
      sipo_stage u_stage (
        .clk(clk),
        .reset(reset),
        .shift_en(sck_rise),
        .shift_in(chain_in[gi]),
        .latch_load(latch_open),
        .latch_clear(clear_act),
        .shift_q(chain_q[gi]),
        .latch_q(latch_q[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Shift chain kept here so the latches can see its next value
  logic [SIPO_WIDTH-1:0] shift_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= SIPO_SHIFT_RST;
    end else begin
      shift_r <= shift_nxt;
    end
  end
  assign shift_q = shift_r;

  logic [SIPO_WIDTH-1:0] par_r;
  logic so_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      par_r <= SIPO_LATCH_RST;
      so_r <= 1'b0;
    end else begin
      if (clear_act) begin
        par_r <= SIPO_CLEARED;
      end else if (latch_open) begin
        par_r <= stage_in;
      end
      so_r <= shift_nxt[SIPO_WIDTH-1];
    end
  end
  assign parallel_outputs = par_r;
  assign serial_out = so_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_SHIFT_ADV: assert property (sck_rise |=>
    shift_r == {$past(shift_r[SIPO_WIDTH-2:0]), $past(serial_data)})
    else $error("shift did not advance");
  AST_HOLD_NO_EDGE: assert property (!sck_rise |=>
    $stable(shift_r))
    else $error("shift moved without an edge");
  AST_HOLD_STB_HIGH: assert property (
    latch_strobe_n && output_clear_n |=> $stable(parallel_outputs))
    else $error("outputs changed with strobe high");
  AST_LOAD_STB_LOW: assert property (
    !latch_strobe_n && output_clear_n |=> parallel_outputs == shift_r)
    else $error("outputs not loaded on strobe low");
  AST_FOLLOW_SHIFT: assert property (
    !latch_strobe_n && output_clear_n && sck_rise
    ##1 !latch_strobe_n && output_clear_n |=> parallel_outputs == shift_r)
    else $error("outputs do not follow shift");
  AST_CLEAR_LOW: assert property (!output_clear_n |=>
    parallel_outputs == SIPO_CLEARED)
    else $error("clear did not blank outputs");
  AST_CLEAR_KEEPS_SHIFT: assert property (
    !output_clear_n && !sck_rise |=> $stable(shift_r))
    else $error("clear disturbed shift register");
  AST_SO_LAST: assert property (1'b1 |=>
    serial_out == shift_r[SIPO_WIDTH-1])
    else $error("cascade out not last stage");
  AST_SO_DEPTH: assert property (sck_rise |=>
    serial_out == $past(shift_r[SIPO_WIDTH-2]))
    else $error("cascade depth wrong");
  AST_CHAIN_MATCH: assert property (1'b1 |=>
    chain_q == shift_r)
    else $error("stage chain differs from shift register");
  AST_LATCH_MATCH: assert property (
    !output_clear_n |=> latch_q == SIPO_CLEARED)
    else $error("stage latches not cleared");

  CVR_SHIFT_HOLD: cover property (sck_rise && latch_strobe_n);
  CVR_LOAD: cover property (latch_strobe_n ##1 !latch_strobe_n);
  CVR_CLEAR: cover property (!output_clear_n ##1 output_clear_n);
endmodule

// [sipo_host.sv]
`timescale 1ns/1ps
module sipo_host (
  input wire logic clk,
  output logic serial_data,
  output logic shift_clock,
  output logic latch_strobe_n,
  output logic output_clear_n
);
  import sipo_pkg::*;
  localparam int HALF = SIPO_MIN_SCK_CYC / 2;
  initial begin
    serial_data = 1'b0;
    shift_clock = 1'b0;
    latch_strobe_n = 1'b1;
    output_clear_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // 20 clk per bit keeps the link at its ceiling
  task automatic shift_bit(input logic b);
    serial_data <= b;
    shift_clock <= 1'b1;
    repeat (HALF) @(posedge clk);
    shift_clock <= 1'b0;
    serial_data <= ~b; // Stale data would hide a late sample
    repeat (HALF) @(posedge clk);
  endtask
  // First bit out lands in the last stage, ready to chain on
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
  endtask
  // No shifting here, so the shift chain holds; strobe low still loads parallel_outputs
  task automatic set_strobe(input logic v);
    latch_strobe_n <= v;
    repeat (2) @(posedge clk);
  endtask
  task automatic set_clear(input logic v);
    output_clear_n <= v;
    repeat (2) @(posedge clk);
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import sipo_pkg::*;
  logic clk, reset, serial_data, shift_clock;
  logic latch_strobe_n, output_clear_n, serial_out;
  logic [SIPO_WIDTH-1:0] parallel_outputs;
  int bad_count = 0;
  int checked = 0;
  sipo_expander dut_u (.clk(clk), .reset(reset), .serial_data(serial_data),
    .shift_clock(shift_clock), .latch_strobe_n(latch_strobe_n),
    .output_clear_n(output_clear_n), .parallel_outputs(parallel_outputs),
    .serial_out(serial_out));
  sipo_host host_u (.clk(clk), .serial_data(serial_data),
    .shift_clock(shift_clock), .latch_strobe_n(latch_strobe_n),
    .output_clear_n(output_clear_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_load();
    host_u.send_word(16'hA5C3);
    chk("so", 16'h0001, {15'h0000, serial_out});
    host_u.set_strobe(1'b0);
    host_u.set_strobe(1'b1);
    chk("par", 16'hA5C3, parallel_outputs);
    $display("test load done");
  endtask
  task automatic t_hold();
    host_u.send_word(16'h3C5A);
    chk("par", 16'hA5C3, parallel_outputs);
    chk("so", 16'h0000, {15'h0000, serial_out});
    $display("test hold done");
  endtask
  task automatic t_clear();
    host_u.set_clear(1'b0);
    chk("par", 16'h0000, parallel_outputs);
    host_u.set_strobe(1'b0);
    chk("par", 16'h0000, parallel_outputs);
    host_u.set_strobe(1'b1);
    chk("so", 16'h0000, {15'h0000, serial_out});
    host_u.set_clear(1'b1);
    host_u.set_strobe(1'b0);
    chk("par", 16'h3C5A, parallel_outputs);
    $display("test clear done");
  endtask
  // Shifts once with strobe low, outputs must track, then once with strobe high, outputs must hold
  task automatic t_follow();
    host_u.shift_bit(1'b1);
    chk("par", 16'h78B5, parallel_outputs);
    host_u.set_strobe(1'b1);
    host_u.shift_bit(1'b0);
    chk("par", 16'h78B5, parallel_outputs);
    $display("test follow done");
  endtask
  initial begin
    reset = 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_load();
    t_hold();
    t_clear();
    t_follow();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
